// ---- shared/flsp_defs.svh ----
// constants for the flash suspend sequencer link and parameter table
`ifndef FLSP_DEFS_SVH
`define FLSP_DEFS_SVH

// clock and timing, times in ns
`define FLSP_CLK_NS        20
`define FLSP_SUSP_MAX_NS   80000
`define FLSP_RSM_GAP_NS    128000
`define FLSP_PP_TYP_NS     512000
`define FLSP_ERASE_TYP_NS  400000
// longest time rounds down
`define FLSP_SUSP_CYC      ((`FLSP_SUSP_MAX_NS) / (`FLSP_CLK_NS))

// link opcodes
`define FLSP_OP_SUSPEND    8'hB0
`define FLSP_OP_RESUME     8'h7A
`define FLSP_OP_READ_PRM   8'h5A
`define FLSP_OP_READ       8'h03
`define FLSP_OP_PAGE_PROG  8'h02
`define FLSP_OP_SECT_ERASE 8'hD8
`define FLSP_OP_CHIP_ERASE 8'h60

// sector field of the 24-bit address (256 KB sectors)
`define FLSP_SECT_MSB      23
`define FLSP_SECT_LSB      18
`define FLSP_ERASED_BYTE   8'hFF

// parameter table: bytes 0..11 = words eleven, twelve, thirteen, lsb first
`define FLSP_PRM_LAST      4'hB
`define FLSP_W11_RSVD31    1'h1
`define FLSP_CE_UNIT       2'h3
`define FLSP_CE_CNT_SMALL  5'h01
`define FLSP_CE_CNT_MID    5'h03
`define FLSP_CE_CNT_LARGE  5'h06
`define FLSP_BP_TYP_NS     5'h1F
`define FLSP_PP_UNIT       1'h1
`define FLSP_PP_CNT        5'h07
`define FLSP_PAGE_EXP      4'h8
`define FLSP_PP_MAX_RATIO  4'h2
`define FLSP_SR_SUPPORTED  1'h0
`define FLSP_ES_LAT_UNIT   2'h2
`define FLSP_ES_LAT_CNT    5'h09
`define FLSP_ES_GAP_CNT    4'h1
`define FLSP_PS_LAT_UNIT   2'h2
`define FLSP_PS_LAT_CNT    5'h09
`define FLSP_PS_GAP_CNT    4'h1
`define FLSP_W12_RSVD8     1'h1
`define FLSP_ES_PROHIBIT   4'hE
`define FLSP_PS_PROHIBIT   4'hC

// host register offsets
`define FLSP_REG_CMD       4'h0
`define FLSP_REG_ADDR      4'h4
`define FLSP_REG_STAT      4'h8
`define FLSP_REG_DATA      4'hC

// host status bit positions
`define FLSP_ST_PEND       0
`define FLSP_ST_DEV_ERR    1
`define FLSP_ST_HOST_ERR   2
`define FLSP_ST_BUSY       3
`define FLSP_ST_SUSP_ER    4
`define FLSP_ST_SUSP_PG    5
`define FLSP_ST_GAP        6

`endif

// ---- shared/flsp_pkg.sv ----
// types used by the device end of the flash suspend sequencer
package flsp_pkg;

    typedef enum logic [4:0] {
        FLSP_IDLE      = 5'h01,
        FLSP_ERASE     = 5'h02,
        FLSP_PROG      = 5'h04,
        FLSP_SUSP_WAIT = 5'h08,
        FLSP_SUSPENDED = 5'h10
    } flsp_state_t;

    typedef enum logic [1:0] {
        FLSP_K_ERASE = 2'h1,
        FLSP_K_PROG  = 2'h2
    } flsp_kind_t;

endpackage : flsp_pkg

// ---- shared/flsp_if.sv ----
// command link between host flash controller and flash device
`timescale 1ns/100ps
interface flsp_if;
    logic        cmd_valid;
    logic [7:0]  cmd_op;
    logic [23:0] cmd_addr;
    logic        rsp_valid;
    logic        rsp_err;
    logic [7:0]  rsp_data;
    logic        busy;
    logic        susp_erase;
    logic        susp_prog;

    modport dev (
        input  cmd_valid, cmd_op, cmd_addr,
        output rsp_valid, rsp_err, rsp_data, busy, susp_erase, susp_prog
    );
    modport host (
        output cmd_valid, cmd_op, cmd_addr,
        input  rsp_valid, rsp_err, rsp_data, busy, susp_erase, susp_prog
    );
endinterface : flsp_if

// ---- rtl/flsp_dev.sv ----
// flash device end: parameter table, program/erase with suspend and resume
//
// Behaviour
// - chip-erase typical count per density
// - word eleven top byte per density
// - byte-program typical times all ones
// - page program unit 64us, count seven
// - page size exponent eight, 256 bytes
// - page program max ratio code two
// - suspend and resume supported bit clear
// - erase suspend latency unit 8us
// - erase suspended within 80us, count nine
// - host waits 128us resume to erase suspend
// - program suspend latency unit 8us
// - program suspended within 80us, count nine
// - host waits 128us resume to program suspend
// - no new erase during erase suspend
// - no program or read in suspended sector
// - erase-suspend prohibited field reads 1110b
// - no erase or program during program suspend
// - program-suspend prohibited field reads 1100b
// - reserved bit eight of word twelve one
// - chip-erase time unit 64 s
// - suspend B0h, resume 7Ah, advertised
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "flsp_defs.svh"

module flsp_dev #(
    parameter int unsigned DENSITY   = 0,
    parameter int unsigned ERASE_CYC = `FLSP_ERASE_TYP_NS / `FLSP_CLK_NS,
    parameter int unsigned PROG_CYC  = `FLSP_PP_TYP_NS / `FLSP_CLK_NS
) (
    input  wire logic CLK_SYS_I,
    input  wire logic SRST_I,
    flsp_if.dev       LNK,
    output logic      OP_DONE_O,
    output logic      SUSPENDED_O
);

    localparam logic [31:0] ERASE_LEN = 32'(ERASE_CYC);
    localparam logic [31:0] PROG_LEN  = 32'(PROG_CYC);
    localparam logic [12:0] SUSP_LEN  = 13'(`FLSP_SUSP_CYC);

    // density picks the chip-erase count; everything else is fixed
    localparam logic [4:0] CE_CNT = (DENSITY == 0) ? `FLSP_CE_CNT_SMALL :
                                    (DENSITY == 1) ? `FLSP_CE_CNT_MID :
                                                     `FLSP_CE_CNT_LARGE;

    localparam logic [31:0] WORD11 = {`FLSP_W11_RSVD31, `FLSP_CE_UNIT, CE_CNT,
                                      `FLSP_BP_TYP_NS, `FLSP_BP_TYP_NS,
                                      `FLSP_PP_UNIT, `FLSP_PP_CNT,
                                      `FLSP_PAGE_EXP,
                                      `FLSP_PP_MAX_RATIO};
    localparam logic [31:0] WORD12 = {`FLSP_SR_SUPPORTED,
                                      `FLSP_ES_LAT_UNIT, `FLSP_ES_LAT_CNT,
                                      `FLSP_ES_GAP_CNT,
                                      `FLSP_PS_LAT_UNIT, `FLSP_PS_LAT_CNT,
                                      `FLSP_PS_GAP_CNT,
                                      `FLSP_W12_RSVD8,
                                      `FLSP_ES_PROHIBIT,
                                      `FLSP_PS_PROHIBIT};
    localparam logic [31:0] WORD13 = {`FLSP_OP_SUSPEND, `FLSP_OP_RESUME,
                                      `FLSP_OP_SUSPEND, `FLSP_OP_RESUME};
    // constants only: no path into the table exists, so writes cannot alter it
    localparam logic [95:0] PRM_TABLE = {WORD13, WORD12, WORD11};

    flsp_pkg::flsp_state_t st_q;
    flsp_pkg::flsp_state_t st_d;
    flsp_pkg::flsp_kind_t  kind_q;
    flsp_pkg::flsp_kind_t  kind_d;

    logic [31:0] op_cnt_q;
    logic [31:0] op_cnt_d;
    logic [31:0] nst_cnt_q;
    logic [31:0] nst_cnt_d;
    logic [12:0] lat_cnt_q;
    logic [12:0] lat_cnt_d;
    logic        nest_q;
    logic        nest_d;
    logic [5:0]  sect_q;
    logic [5:0]  sect_d;
    logic        rsp_valid_q;
    logic        rsp_err_q;
    logic        rsp_err_d;
    logic [7:0]  rsp_data_q;
    logic [7:0]  rsp_data_d;
    logic        busy_q;
    logic        susp_er_q;
    logic        susp_pg_q;
    logic        susp_any_q;
    logic        done_q;
    logic        done_d;

    // command decode
    wire         cmd       = LNK.cmd_valid;
    wire         is_susp   = cmd && (LNK.cmd_op == `FLSP_OP_SUSPEND);
    wire         is_rsm    = cmd && (LNK.cmd_op == `FLSP_OP_RESUME);
    wire         is_prm    = cmd && (LNK.cmd_op == `FLSP_OP_READ_PRM);
    wire         is_read   = cmd && (LNK.cmd_op == `FLSP_OP_READ);
    wire         is_prog   = cmd && (LNK.cmd_op == `FLSP_OP_PAGE_PROG);
    wire         is_erase  = cmd && ((LNK.cmd_op == `FLSP_OP_SECT_ERASE) ||
                                     (LNK.cmd_op == `FLSP_OP_CHIP_ERASE));
    wire         is_known  = is_susp || is_rsm || is_prm || is_read || is_prog || is_erase;
    wire [5:0]   cmd_sect  = LNK.cmd_addr[`FLSP_SECT_MSB:`FLSP_SECT_LSB];
    wire [3:0]   prm_idx   = LNK.cmd_addr[3:0];
    wire         prm_ok    = prm_idx <= `FLSP_PRM_LAST;
    wire [7:0]   prm_byte  = prm_ok ? PRM_TABLE[{prm_idx, 3'h0} +: 8] : `FLSP_ERASED_BYTE;

    wire         in_idle   = st_q == flsp_pkg::FLSP_IDLE;
    wire         in_susp   = st_q == flsp_pkg::FLSP_SUSPENDED;
    wire         er_held   = (in_susp || nest_q) && (kind_q == flsp_pkg::FLSP_K_ERASE);
    wire         same_sect = cmd_sect == sect_q;
    wire         top_run   = ((st_q == flsp_pkg::FLSP_ERASE) || (st_q == flsp_pkg::FLSP_PROG))
                             && !nest_q;

    // a page program is allowed beside a suspended erase, outside its sector
    wire         prog_ok   = in_idle || (in_susp && !nest_q &&
                             (kind_q == flsp_pkg::FLSP_K_ERASE) && !same_sect);
    wire         erase_ok  = in_idle;
    wire         read_ok   = (in_idle || in_susp) && !(er_held && same_sect);
    wire         susp_ok   = top_run;
    wire         rsm_ok    = in_susp;

    always_comb begin
        st_d       = st_q;
        kind_d     = kind_q;
        op_cnt_d   = op_cnt_q;
        nst_cnt_d  = nst_cnt_q;
        lat_cnt_d  = lat_cnt_q;
        nest_d     = nest_q;
        sect_d     = sect_q;
        done_d     = 1'b0;
        rsp_err_d  = 1'b0;
        rsp_data_d = `FLSP_ERASED_BYTE;
        case (st_q)
            flsp_pkg::FLSP_IDLE: begin
                if (is_erase && erase_ok) begin
                    st_d     = flsp_pkg::FLSP_ERASE;
                    kind_d   = flsp_pkg::FLSP_K_ERASE;
                    sect_d   = cmd_sect;
                    op_cnt_d = ERASE_LEN;
                end else if (is_prog && prog_ok) begin
                    st_d     = flsp_pkg::FLSP_PROG;
                    kind_d   = flsp_pkg::FLSP_K_PROG;
                    sect_d   = cmd_sect;
                    op_cnt_d = PROG_LEN;
                end
            end
            flsp_pkg::FLSP_ERASE,
            flsp_pkg::FLSP_PROG: begin
                if (nest_q) begin
                    if (nst_cnt_q <= 32'h0000_0001) begin
                        // nested program done: the erase stays suspended
                        st_d   = flsp_pkg::FLSP_SUSPENDED;
                        nest_d = 1'b0;
                        done_d = 1'b1;
                    end else begin
                        nst_cnt_d = nst_cnt_q - 32'h0000_0001;
                    end
                end else if (is_susp) begin
                    st_d      = flsp_pkg::FLSP_SUSP_WAIT;
                    lat_cnt_d = SUSP_LEN;
                end else if (op_cnt_q <= 32'h0000_0001) begin
                    st_d   = flsp_pkg::FLSP_IDLE;
                    done_d = 1'b1;
                end else begin
                    op_cnt_d = op_cnt_q - 32'h0000_0001;
                end
            end
            flsp_pkg::FLSP_SUSP_WAIT: begin
                // progress freezes while the array is brought to a safe point
                if (lat_cnt_q <= 13'h0001) begin
                    st_d = flsp_pkg::FLSP_SUSPENDED;
                end else begin
                    lat_cnt_d = lat_cnt_q - 13'h0001;
                end
            end
            flsp_pkg::FLSP_SUSPENDED: begin
                if (is_rsm && rsm_ok) begin
                    st_d = (kind_q == flsp_pkg::FLSP_K_ERASE) ? flsp_pkg::FLSP_ERASE
                                                              : flsp_pkg::FLSP_PROG;
                end else if (is_prog && prog_ok) begin
                    st_d      = flsp_pkg::FLSP_PROG;
                    nest_d    = 1'b1;
                    nst_cnt_d = PROG_LEN;
                end
            end
            default: begin
                st_d = flsp_pkg::FLSP_IDLE;
            end
        endcase
        // every command gets one answer; a refusal leaves the held op untouched
        if (is_prm) begin
            rsp_data_d = prm_byte;
            rsp_err_d  = !prm_ok;
        end else if (is_read) begin
            rsp_err_d = !read_ok;
        end else if (is_prog) begin
            rsp_err_d = !prog_ok;
        end else if (is_erase) begin
            rsp_err_d = !erase_ok;
        end else if (is_susp) begin
            rsp_err_d = !susp_ok;
        end else if (is_rsm) begin
            rsp_err_d = !rsm_ok;
        end else if (cmd && !is_known) begin
            rsp_err_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            st_q      <= flsp_pkg::FLSP_IDLE;
            kind_q    <= flsp_pkg::FLSP_K_ERASE;
            op_cnt_q  <= 32'h0000_0000;
            nst_cnt_q <= 32'h0000_0000;
            lat_cnt_q <= 13'h0000;
            nest_q    <= 1'b0;
            sect_q    <= 6'h00;
        end else begin
            st_q      <= st_d;
            kind_q    <= kind_d;
            op_cnt_q  <= op_cnt_d;
            nst_cnt_q <= nst_cnt_d;
            lat_cnt_q <= lat_cnt_d;
            nest_q    <= nest_d;
            sect_q    <= sect_d;
        end
    end

    // flags follow the next state so they change together with the state register
    wire         susp_er_d = ((st_d == flsp_pkg::FLSP_SUSPENDED) || nest_d) &&
                             (kind_d == flsp_pkg::FLSP_K_ERASE);
    wire         susp_pg_d = (st_d == flsp_pkg::FLSP_SUSPENDED) &&
                             (kind_d == flsp_pkg::FLSP_K_PROG);

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            rsp_valid_q <= 1'b0;
            rsp_err_q   <= 1'b0;
            rsp_data_q  <= 8'h00;
            busy_q      <= 1'b0;
            susp_er_q   <= 1'b0;
            susp_pg_q   <= 1'b0;
            susp_any_q  <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            rsp_valid_q <= cmd;
            rsp_err_q   <= rsp_err_d;
            rsp_data_q  <= rsp_data_d;
            busy_q      <= st_d != flsp_pkg::FLSP_IDLE;
            susp_er_q   <= susp_er_d;
            susp_pg_q   <= susp_pg_d;
            susp_any_q  <= susp_er_d || susp_pg_d;
            done_q      <= done_d;
        end
    end

    assign LNK.rsp_valid  = rsp_valid_q;
    assign LNK.rsp_err    = rsp_err_q;
    assign LNK.rsp_data   = rsp_data_q;
    assign LNK.busy       = busy_q;
    assign LNK.susp_erase = susp_er_q;
    assign LNK.susp_prog  = susp_pg_q;
    assign OP_DONE_O      = done_q;
    assign SUSPENDED_O    = susp_any_q;

endmodule : flsp_dev

// ---- rtl/flsp_host.sv ----
// host flash controller end: register port in, guarded commands out
`timescale 1ns/100ps
`include "flsp_defs.svh"

module flsp_host #(
    parameter int unsigned RSM_GAP_CYC =
        (`FLSP_RSM_GAP_NS + `FLSP_CLK_NS - 1) / `FLSP_CLK_NS
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        SRST_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    flsp_if.host             LNK
);

    localparam logic [15:0] GAP_LEN = 16'(RSM_GAP_CYC);

    logic [23:0] addr_q;
    logic [5:0]  sect_q;
    logic [15:0] gap_q;
    logic        pend_q;
    logic        dev_err_q;
    logic        host_err_q;
    logic        cv_q;
    logic [7:0]  op_q;
    logic [23:0] ca_q;
    logic [7:0]  data_q;
    logic [31:0] rdata_q;

    wire [7:0] op       = WDATA_I[7:0];
    wire       wr_cmd   = WR_I && (ADDR_I == `FLSP_REG_CMD);
    wire       wr_addr  = WR_I && (ADDR_I == `FLSP_REG_ADDR);
    wire       o_erase  = (op == `FLSP_OP_SECT_ERASE) || (op == `FLSP_OP_CHIP_ERASE);
    wire       o_prog   = op == `FLSP_OP_PAGE_PROG;
    wire       o_read   = op == `FLSP_OP_READ;
    wire       o_susp   = op == `FLSP_OP_SUSPEND;
    wire       o_rsm    = op == `FLSP_OP_RESUME;
    wire       same_sec = addr_q[`FLSP_SECT_MSB:`FLSP_SECT_LSB] == sect_q;
    wire       gap_on   = gap_q != 16'h0000;

    // the host holds itself back; the device refuses these too, except a suspend too soon after resume, which only the host checks
    wire bad_gap   = o_susp && gap_on;
    wire bad_erase = o_erase && (LNK.susp_erase || LNK.susp_prog);
    wire bad_prog  = o_prog && (LNK.susp_prog || (LNK.susp_erase && same_sec));
    wire bad_read  = o_read && LNK.susp_erase && same_sec;
    wire refuse    = pend_q || bad_gap || bad_erase || bad_prog || bad_read;
    wire issue     = wr_cmd && !refuse;

    wire [31:0] stat = {25'h000_0000, gap_on, LNK.susp_prog, LNK.susp_erase, LNK.busy,
                        host_err_q, dev_err_q, pend_q};
    wire [31:0] rd_mux = (ADDR_I == `FLSP_REG_ADDR) ? {8'h00, addr_q} :
                         (ADDR_I == `FLSP_REG_STAT) ? stat :
                         (ADDR_I == `FLSP_REG_DATA) ? {24'h00_0000, data_q} :
                                                      32'h0000_0000;

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            addr_q <= 24'h00_0000;
            sect_q <= 6'h00;
            cv_q   <= 1'b0;
            op_q   <= 8'h00;
            ca_q   <= 24'h00_0000;
        end else begin
            if (wr_addr) begin
                addr_q <= WDATA_I[23:0];
            end
            if (issue && o_erase) begin
                sect_q <= addr_q[`FLSP_SECT_MSB:`FLSP_SECT_LSB];
            end
            cv_q <= issue;
            if (issue) begin
                op_q <= op;
                ca_q <= addr_q;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            gap_q      <= 16'h0000;
            pend_q     <= 1'b0;
            dev_err_q  <= 1'b0;
            host_err_q <= 1'b0;
            data_q     <= 8'h00;
            rdata_q    <= 32'h0000_0000;
        end else begin
            // interval counts from the resume leaving the host
            if (issue && o_rsm) begin
                gap_q <= GAP_LEN;
            end else if (gap_on) begin
                gap_q <= gap_q - 16'h0001;
            end
            if (issue) begin
                pend_q <= 1'b1;
            end else if (LNK.rsp_valid) begin
                pend_q <= 1'b0;
            end
            if (wr_cmd) begin
                host_err_q <= refuse;
            end
            if (issue) begin
                dev_err_q <= 1'b0;
            end else if (LNK.rsp_valid) begin
                dev_err_q <= LNK.rsp_err;
            end
            if (LNK.rsp_valid) begin
                data_q <= LNK.rsp_data;
            end
            rdata_q <= RD_I ? rd_mux : 32'h0000_0000;
        end
    end

    assign LNK.cmd_valid = cv_q;
    assign LNK.cmd_op    = op_q;
    assign LNK.cmd_addr  = ca_q;
    assign RDATA_O       = rdata_q;

endmodule : flsp_host

// ---- verification/flsp_asserts.sv ----
// concurrent checks on the suspend command link
`timescale 1ns/100ps
module flsp_asserts #(
    parameter int unsigned DENSITY     = 0,
    parameter int unsigned RSM_GAP_CYC = 20
) (
    input wire logic        CLK_SYS_I,
    input wire logic        SRST_I,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_op,
    input wire logic [23:0] cmd_addr,
    input wire logic        rsp_valid,
    input wire logic        rsp_err,
    input wire logic [7:0]  rsp_data,
    input wire logic        busy,
    input wire logic        susp_erase,
    input wire logic        susp_prog
);
    // three cycles of slack over the fixed 4000-cycle suspend latency
    localparam int LAT_MAX = 4003;
    wire logic [7:0] top_exp = (DENSITY == 0) ? 8'hE1 : (DENSITY == 1) ? 8'hE3 : 8'hE6;
    wire logic       prm_rd  = cmd_valid && cmd_op == 8'h5A;
    wire logic       is_ers  = cmd_valid && (cmd_op == 8'hD8 || cmd_op == 8'h60);
    wire logic       is_prg  = cmd_valid && cmd_op == 8'h02;
    logic            sus_q;
    logic            wait_q;
    logic [12:0]     lat_q;
    logic [5:0]      sect_q;
    logic [15:0]     since_q;

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            sus_q   <= 1'b0;
            wait_q  <= 1'b0;
            lat_q   <= 13'h0000;
            sect_q  <= 6'h00;
            since_q <= 16'hFFFF;
        end else begin
            sus_q <= cmd_valid && cmd_op == 8'hB0;
            if (sus_q && rsp_valid && !rsp_err) wait_q <= 1'b1;
            else if (susp_erase || susp_prog) wait_q <= 1'b0;
            lat_q <= wait_q ? lat_q + 13'h0001 : 13'h0000;
            if (cmd_valid && cmd_op == 8'hD8) sect_q <= cmd_addr[23:18];
            if (cmd_valid && cmd_op == 8'h7A) since_q <= 16'h0000;
            else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);

    answer_next_a: assert property (cmd_valid |=> rsp_valid)
        else $error("command not answered next cycle");
    w11_low_a: assert property (prm_rd && cmd_addr[3:0] == 4'h0 |=> rsp_data == 8'h82)
        else $error("word eleven low byte wrong");
    w11_top_a: assert property (prm_rd && cmd_addr[3:0] == 4'h3 |=> rsp_data == top_exp)
        else $error("word eleven top byte wrong");
    w12_low_a: assert property (prm_rd && cmd_addr[3:0] == 4'h4 |=> rsp_data == 8'hEC)
        else $error("word twelve low byte wrong");
    w12_top_a: assert property (prm_rd && cmd_addr[3:0] == 4'h7 |=> rsp_data == 8'h49)
        else $error("word twelve top byte wrong");
    susp_latency_a: assert property (wait_q |-> lat_q <= LAT_MAX)
        else $error("suspend latency exceeded");
    erase_nest_a: assert property (susp_erase |-> !is_ers)
        else $error("erase issued during erase suspend");
    sector_guard_a: assert property (susp_erase && (is_prg || cmd_valid && cmd_op == 8'h03)
        |-> cmd_addr[23:18] != sect_q)
        else $error("access to erase-suspended sector");
    prog_nest_a: assert property (susp_prog |-> !(is_ers || is_prg))
        else $error("erase or program during program suspend");
    resume_gap_a: assert property (cmd_valid && cmd_op == 8'hB0 |-> since_q + 2 >= RSM_GAP_CYC)
        else $error("suspend too soon after resume");
    susp_busy_a: assert property ((susp_erase || susp_prog) |-> busy)
        else $error("suspended without busy");

    cover property ($rose(susp_erase));
    cover property ($rose(susp_prog));
    cover property (rsp_valid && rsp_err);
endmodule : flsp_asserts

// ---- verification/flsp_tb_top.sv ----
// self-checking bench for host and device ends joined by the link
`timescale 1ns/100ps
`include "flsp_defs.svh"
module flsp_tb_top;
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic        op_done;
    logic        suspended;
    int          fails = 0;
    int          total_checks = 0;
    int          done_cnt = 0;
    logic [7:0]  tbl [12] = '{8'h82, 8'hE7, 8'hFF, 8'hE3, 8'hEC, 8'h23, 8'h19, 8'h49,
                              8'h7A, 8'hB0, 8'h7A, 8'hB0};

    flsp_if lnk ();
    flsp_dev #(.DENSITY(1), .ERASE_CYC(50), .PROG_CYC(40)) flsp_dev_i (
        .CLK_SYS_I(clk), .SRST_I(srst), .LNK(lnk), .OP_DONE_O(op_done),
        .SUSPENDED_O(suspended));
    flsp_host #(.RSM_GAP_CYC(20)) flsp_host_i (
        .CLK_SYS_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .LNK(lnk));
    flsp_asserts #(.DENSITY(1)) flsp_asserts_i (
        .CLK_SYS_I(clk), .SRST_I(srst), .cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op),
        .cmd_addr(lnk.cmd_addr), .rsp_valid(lnk.rsp_valid), .rsp_err(lnk.rsp_err),
        .rsp_data(lnk.rsp_data), .busy(lnk.busy), .susp_erase(lnk.susp_erase),
        .susp_prog(lnk.susp_prog));

    always #10 clk = ~clk;
    always @(posedge clk) if (op_done === 1'b1) done_cnt++;

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // the extra edge keeps a strobe from being set twice in one time step
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
        @(posedge clk);
    endtask : rd_reg

    task automatic issue(input logic [7:0] op, input logic [23:0] a);
        wr_reg(`FLSP_REG_ADDR, {8'h00, a});
        wr_reg(`FLSP_REG_CMD, {24'h00_0000, op});
        repeat (3) @(posedge clk);
    endtask : issue

    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rd_reg(`FLSP_REG_STAT);
        chk(rv & m, e);
    endtask : st

    task automatic wait_st(input int b, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            rd_reg(`FLSP_REG_STAT);
            if (rv[b] === v) return;
        end
        fails++;
        $display("[ERR] %0t status bit %0d never settled", $time, b);
    endtask : wait_st

    task automatic prm(input logic [3:0] i, input logic [7:0] e);
        issue(`FLSP_OP_READ_PRM, {20'h0_0000, i});
        rd_reg(`FLSP_REG_DATA);
        chk(rv & 32'h0000_00FF, {24'h00_0000, e});
    endtask : prm

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 12; i++) prm(i[3:0], tbl[i]);
        issue(`FLSP_OP_READ_PRM, 24'h00_000C);
        st(32'h0000_0006, 32'h0000_0002);
        wr_reg(`FLSP_REG_DATA, 32'h0000_0000);
        rd_reg(4'h2);
        chk(rv, 32'h0000_0000);
        prm(4'h0, 8'h82);
        issue(`FLSP_OP_SUSPEND, 24'h00_0000);
        st(32'h0000_0006, 32'h0000_0002);
        $display("parameter table test done");
        issue(`FLSP_OP_SECT_ERASE, 24'h04_0000);
        issue(`FLSP_OP_SUSPEND, 24'h00_0000);
        wait_st(`FLSP_ST_SUSP_ER, 1'b1, 2100);
        issue(`FLSP_OP_CHIP_ERASE, 24'h00_0000);
        st(32'h0000_0004, 32'h0000_0004);
        issue(`FLSP_OP_PAGE_PROG, 24'h04_0010);
        st(32'h0000_0004, 32'h0000_0004);
        issue(`FLSP_OP_READ, 24'h04_0000);
        st(32'h0000_0004, 32'h0000_0004);
        issue(`FLSP_OP_READ, 24'h08_0000);
        st(32'h0000_0006, 32'h0000_0000);
        issue(`FLSP_OP_PAGE_PROG, 24'h08_0000);
        st(32'h0000_0006, 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk(done_cnt, 1);
        st(32'h0000_0018, 32'h0000_0018);
        issue(`FLSP_OP_RESUME, 24'h00_0000);
        issue(`FLSP_OP_SUSPEND, 24'h00_0000);
        st(32'h0000_0004, 32'h0000_0004);
        wait_st(`FLSP_ST_BUSY, 1'b0, 100);
        st(32'h0000_0030, 32'h0000_0000);
        chk(done_cnt, 2);
        $display("erase suspend test done");
        issue(`FLSP_OP_PAGE_PROG, 24'h00_0000);
        issue(`FLSP_OP_SUSPEND, 24'h00_0000);
        wait_st(`FLSP_ST_SUSP_PG, 1'b1, 2100);
        chk({31'h0000_0000, suspended}, 32'h0000_0001);
        issue(`FLSP_OP_SECT_ERASE, 24'h08_0000);
        st(32'h0000_0004, 32'h0000_0004);
        issue(`FLSP_OP_PAGE_PROG, 24'h08_0000);
        st(32'h0000_0004, 32'h0000_0004);
        issue(`FLSP_OP_RESUME, 24'h00_0000);
        issue(`FLSP_OP_SUSPEND, 24'h00_0000);
        st(32'h0000_0004, 32'h0000_0004);
        wait_st(`FLSP_ST_BUSY, 1'b0, 100);
        chk(done_cnt, 3);
        $display("program suspend test done");
        summarize();
    end
endmodule : flsp_tb_top
